/* pkg/epw_defines.svh */
// Register offsets, channel count and reset values of the PWM timer
// Included by the timer and the testbench; definitions only
`ifndef EPW_DEFINES_SVH
`define EPW_DEFINES_SVH
`define EPW_NCH         8
`define EPW_OFF_ENABLE  12'h000
`define EPW_OFF_POL     12'h004
`define EPW_OFF_CENTER  12'h008
`define EPW_OFF_CONCAT  12'h00C
`define EPW_OFF_OUT     12'h010
`define EPW_OFF_PER0    12'h020
`define EPW_OFF_DTY0    12'h040
`define EPW_OFF_CNT0    12'h060
`define EPW_RST_PER     8'hFF
`define EPW_RST_DTY     8'h00
`define EPW_RST_CTRL    8'h00
`endif

/* pkg/epw_pkg.sv */
// Types shared by the PWM timer files
// Assumes epw_defines.svh for the numbers
package epw_pkg;
  typedef logic [7:0]  epw_byte_t;
  typedef logic [15:0] epw_word_t;
endpackage

/* pkg/epw_ch_if.sv */
// Settings and state carried between the timer top and one channel pair
// Assumes one instance per channel pair, driven by the top
`timescale 1ns/1ps
`default_nettype none
interface epw_ch_if;
  logic              en_lo;
  logic              en_hi;
  logic              pol_lo;
  logic              pol_hi;
  logic              ctr_lo;
  logic              ctr_hi;
  logic              joined;
  epw_pkg::epw_word_t per;
  epw_pkg::epw_word_t dty;
  epw_pkg::epw_word_t cnt;
  logic              out_lo;
  logic              out_hi;
  modport top (output en_lo, en_hi, pol_lo, pol_hi, ctr_lo, ctr_hi,
               joined, per, dty, input cnt, out_lo, out_hi);
  modport pair (input en_lo, en_hi, pol_lo, pol_hi, ctr_lo, ctr_hi,
                joined, per, dty, output cnt, out_lo, out_hi);
endinterface
`default_nettype wire

/* rtl/epw_pair.sv */
// Two 8-bit PWM channels that can join into one 16-bit channel
// Assumes settings come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module epw_pair
(
  input  wire logic hclk,
  input  wire logic hresetn,
  epw_ch_if.pair    ch
);
  logic [7:0] clo_q;
  logic [7:0] chi_q;
  logic       dlo_q;
  logic       dhi_q;
  logic       olo_q;
  logic       ohi_q;
  logic       dj_q;
  logic [7:0] clo_d;
  logic [7:0] chi_d;
  logic       dlo_d;
  logic       dhi_d;
  logic       dj_d;
  logic [15:0] cj;
  logic [15:0] cj_d;
  logic        act_lo;
  logic        act_hi;
  logic        act_j;

  // Next count of one 8-bit channel: up to period-1, or up/down in centre
  function automatic logic [8:0] step8(input logic [7:0] c,
                                       input logic       d,
                                       input logic       ctr,
                                       input logic [7:0] p);
    logic [8:0] r;
    r = {c, d};
    if (!ctr)
    begin
      r = (c >= p - 8'h01) ? 9'h000 : {c + 8'h01, 1'b0};
    end
    else if (!d)
    begin
      r = (c >= p) ? {c - 8'h01, 1'b1} : {c + 8'h01, 1'b0};
    end
    else
    begin
      r = (c == 8'h00) ? {8'h01, 1'b0} : {c - 8'h01, 1'b1};
    end
    return r;
  endfunction

  // Counting for separate channels and for the joined 16-bit channel
  assign cj = {chi_q, clo_q};
  assign {clo_d, dlo_d} = ch.en_lo ? step8(clo_q, dlo_q, ch.ctr_lo,
                            ch.per[7:0]) : 9'h000;
  assign {chi_d, dhi_d} = ch.en_hi ? step8(chi_q, dhi_q, ch.ctr_hi,
                            ch.per[15:8]) : 9'h000;
  assign cj_d = !ch.en_hi ? 16'h0000 :
                !ch.ctr_hi ? ((cj >= ch.per - 16'h0001) ? 16'h0000
                              : cj + 16'h0001) :
                (!dj_q ? ((cj >= ch.per) ? cj - 16'h0001 : cj + 16'h0001)
                       : ((cj == 16'h0000) ? 16'h0001
                                           : cj - 16'h0001));
  assign dj_d = ch.en_hi && ch.ctr_hi &&
                (!dj_q ? (cj >= ch.per) : (cj != 16'h0000));
  // Active while count below duty: duty 0 never, always at duty >= period in up count, duty > period in centre
  assign act_lo = clo_q < ch.dty[7:0];
  assign act_hi = chi_q < ch.dty[15:8];
  assign act_j  = cj < ch.dty;
  assign ch.cnt = cj;
  assign ch.out_lo = olo_q;
  assign ch.out_hi = ohi_q;

  // Counters and registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clo_q <= 8'h00;
      chi_q <= 8'h00;
      dlo_q <= 1'b0;
      dhi_q <= 1'b0;
      dj_q  <= 1'b0;
      olo_q <= 1'b0;
      ohi_q <= 1'b0;
    end
    else if (ch.joined)
    begin
      {chi_q, clo_q} <= cj_d;
      dj_q  <= dj_d;
      olo_q <= 1'b0;
      ohi_q <= ch.en_hi ? (act_j ~^ ch.pol_hi) : ch.pol_hi;
    end
    else
    begin
      clo_q <= clo_d;
      chi_q <= chi_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      olo_q <= ch.en_lo ? (act_lo ~^ ch.pol_lo) : ch.pol_lo;
      ohi_q <= ch.en_hi ? (act_hi ~^ ch.pol_hi) : ch.pol_hi;
    end
  end
endmodule
`default_nettype wire

/* rtl/epw_timer.sv */
// Eight-channel PWM timer with an AHB-Lite register slave
// Assumes one hclk domain; pwm_out goes straight to pins
// Function
// - eight independent channels, each with its own 8-bit counter
// - each channel repeats a waveform from its period and duty
// - duty spans fully inactive through fully active output
// - per-channel polarity chooses whether active portion is high or low
// - left-aligned up count or centre-aligned up/down count per channel
// - pairs 7:6, 5:4, 3:2, 1:0 join into 16-bit channels
//
// Chosen here: the register offsets and register access over AHB-Lite.
`include "epw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module epw_timer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [7:0]  pwm_out
);
  localparam int NCH = `EPW_NCH;

  // Register map, one aligned word each, data in bits 7:0
  //   enable    one bit per channel, a disabled channel rests at polarity
  //   polarity  one bit per channel, 1 drives the active portion high
  //   centre    one bit per channel, 1 selects up/down counting
  //   concat    bit g joins channels 2g+1 and 2g into one 16-bit channel
  //   output    read-only image of the eight pin levels
  //   period    table of eight bytes, one per channel
  //   duty      table of eight bytes, one per channel
  //   counter   read-only, low and high byte of each pair's count
  // Settings act at once; there is no buffering to the period end,
  // so a write in mid-period can give one short or long cycle.
  // Only word transfers are taken; other sizes read zero, write nothing.

  // Control and table registers
  logic [7:0]  en_q;
  logic [7:0]  pol_q;
  logic [7:0]  ctr_q;
  logic [3:0]  cat_q;
  epw_pkg::epw_byte_t per_q [NCH];
  epw_pkg::epw_byte_t dty_q [NCH];
  logic        wr_q;
  logic [11:0] wa_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic        take;
  logic        rd_req;
  logic [15:0] cnt [NCH/2];


  // Channel index of a per-channel table address, or 4'hF when outside
  function automatic logic [3:0] tab_idx(input logic [11:0] a,
                                         input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    return (a >= base && off < 12'h020 && off[1:0] == 2'b00)
           ? {1'b0, off[4:2]} : 4'hF;
  endfunction

  // Address phase taken; slave always ready with OKAY
  assign rd_req    = hsel && hready && htrans[1] && !hwrite;
  assign take      = hsel && hready && htrans[1] && hsize == 3'b010;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_q;

  // Each pair sees its channels' bits and joined bytes through one
  // interface; the odd channel's byte is the upper half of the pair.
  // Pair instances
  genvar g;
  generate
    for (g = 0; g < NCH/2; g++)
    begin : gp
      epw_ch_if cif ();
      assign cif.en_lo  = en_q[2*g];
      assign cif.en_hi  = en_q[2*g+1];
      assign cif.pol_lo = pol_q[2*g];
      assign cif.pol_hi = pol_q[2*g+1];
      assign cif.ctr_lo = ctr_q[2*g];
      assign cif.ctr_hi = ctr_q[2*g+1];
      assign cif.joined = cat_q[g];
      assign cif.per    = {per_q[2*g+1], per_q[2*g]};
      assign cif.dty    = {dty_q[2*g+1], dty_q[2*g]};
      assign cnt[g]     = cif.cnt;
      assign pwm_out[2*g]   = cif.out_lo;
      assign pwm_out[2*g+1] = cif.out_hi;
      epw_pair u_pair
      (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ch      (cif.pair)
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    logic [3:0] ip;
    logic [3:0] id;
    logic [3:0] ic;
    ip = tab_idx(haddr, `EPW_OFF_PER0);
    id = tab_idx(haddr, `EPW_OFF_DTY0);
    ic = tab_idx(haddr, `EPW_OFF_CNT0);
    rd_d = 32'h0000_0000;
    if (haddr == `EPW_OFF_ENABLE) rd_d = {24'h0, en_q};
    else if (haddr == `EPW_OFF_POL) rd_d = {24'h0, pol_q};
    else if (haddr == `EPW_OFF_CENTER) rd_d = {24'h0, ctr_q};
    else if (haddr == `EPW_OFF_CONCAT) rd_d = {28'h0, cat_q};
    else if (haddr == `EPW_OFF_OUT) rd_d = {24'h0, pwm_out};
    else if (ip != 4'hF) rd_d = {24'h0, per_q[ip[2:0]]};
    else if (id != 4'hF) rd_d = {24'h0, dty_q[id[2:0]]};
    else if (ic != 4'hF)
      rd_d = ic[0] ? {24'h0, cnt[ic[2:1]][15:8]}
                   : {24'h0, cnt[ic[2:1]][7:0]};
  end


  // Address phase capture and read data; refused reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 12'h000;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= take && hwrite;
      wa_q <= haddr;
      if (rd_req)
        rd_q <= take ? rd_d : 32'h0000_0000;
    end
  end


  // Control registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q  <= `EPW_RST_CTRL;
      pol_q <= `EPW_RST_CTRL;
      ctr_q <= `EPW_RST_CTRL;
      cat_q <= 4'h0;
    end
    else if (wr_q)
    begin
      if (wa_q == `EPW_OFF_ENABLE) en_q <= hwdata[7:0];
      if (wa_q == `EPW_OFF_POL) pol_q <= hwdata[7:0];
      if (wa_q == `EPW_OFF_CENTER) ctr_q <= hwdata[7:0];
      if (wa_q == `EPW_OFF_CONCAT) cat_q <= hwdata[3:0];
    end
  end


  // Period and duty tables, one byte per channel
  generate
    for (g = 0; g < NCH; g++)
    begin : gr
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          per_q[g] <= `EPW_RST_PER;
          dty_q[g] <= `EPW_RST_DTY;
        end
        else if (wr_q)
        begin
          if (tab_idx(wa_q, `EPW_OFF_PER0) == 4'(g))
            per_q[g] <= hwdata[7:0];
          if (tab_idx(wa_q, `EPW_OFF_DTY0) == 4'(g))
            dty_q[g] <= hwdata[7:0];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* verif/epw_timer_props.sv */
// Port checker for the PWM timer
// Bound to epw_timer; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module epw_timer_props
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  pwm_out
);
  logic        wv_q;
  logic [11:0] wa_q;
  logic [7:0]  sh_q [4];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of enable, polarity and join registers from bus writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wv_q <= 1'h0;
      wa_q <= 12'h000;
      sh_q <= '{default: 8'h00};
    end
    else
    begin
      wv_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      wa_q <= haddr;
      if (wv_q && wa_q[11:4] == 8'h00)
        sh_q[wa_q[3:2]] <= hwdata[7:0];
    end
  a_rst_idle: assert property ($rose(hresetn) |-> pwm_out == 8'h00)
    else $error("outputs not idle after reset");
  a_bus_okay: assert property (hresp == 1'h0 && hreadyout == 1'h1)
    else $error("bus response not zero-wait OKAY");
  a_join_low0: assert property (sh_q[3][0] [*3] |-> !pwm_out[0])
    else $error("joined lower output 0 not quiet");
  a_join_low6: assert property (sh_q[3][3] [*3] |-> !pwm_out[6])
    else $error("joined lower output 6 not quiet");
  a_idle_pol: assert property ((!sh_q[0][7] && $stable(sh_q[1][7])) [*3]
    |-> pwm_out[7] == sh_q[1][7])
    else $error("disabled output 7 not at polarity");
  a_size_zero: assert property (hsel && hready && htrans[1] && !hwrite
    && hsize != 3'h2 |=> hrdata == 32'h0)
    else $error("non-word read not zero");
  a_byte_only: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
endmodule
bind epw_timer epw_timer_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out));
`default_nettype wire

/* verif/epw_timer_tb.sv */
// Self-checking bench for the PWM timer
// Drives the AHB-Lite port itself; hready follows hreadyout
`include "epw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module epw_timer_tb;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rdat;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pwm_out;
  wire logic   hready;
  int          errors = 0;
  int          n_checks = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  epw_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out));
  // Verdict and end of run
  task automatic stop_test;
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("Error %s exp %h got %h", nm, e, g);
      errors++;
    end
  endtask
  // Wait for ready at a rising edge, bounded
  task automatic hs;
    int i;
    i = 0;
    @(posedge hclk);
    while (hready !== 1'h1)
    begin
      i++;
      if (i > 50)
      begin
        errors++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask
  // One single transfer at the current hsize; read data lands in rdat
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hs();
    htrans <= 2'h0;
    hwdata <= d;
    hs();
    rdat = hrdata;
  endtask
  // Count high samples of one output over n cycles after settling
  task automatic cnt(input int c, input int n, input int e);
    int k;
    k = 0;
    repeat (8) @(negedge hclk);
    repeat (n)
    begin
      @(negedge hclk);
      if (pwm_out[c] === 1'h1)
        k++;
    end
    chk("pwm_high", e, k);
  endtask
  task automatic t_reset;
    chk("pwm_rst", 32'h0, {24'h0, pwm_out});
    chk("okay", 32'h2, {30'h0, hreadyout, hresp});
    xfer(1'h0, `EPW_OFF_PER0, 32'h0);
    chk("per_rst", {24'h0, `EPW_RST_PER}, rdat);
    xfer(1'h0, `EPW_OFF_CNT0 + 12'h010, 32'h0);
    chk("cnt_idle", 32'h0, rdat);
  endtask
  task automatic t_left;
    logic [31:0] dt[3] = '{32'h4, 32'h0, 32'h1};
    int          ex[3] = '{16, 0, 4};
    xfer(1'h1, `EPW_OFF_PER0, 32'h4);
    xfer(1'h1, `EPW_OFF_POL, 32'h1);
    xfer(1'h1, `EPW_OFF_ENABLE, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'h1, `EPW_OFF_DTY0, dt[i]);
      cnt(0, 16, ex[i]);
    end
    xfer(1'h1, `EPW_OFF_POL, 32'h0);
    cnt(0, 16, 12);
  endtask
  task automatic t_centre;
    xfer(1'h1, `EPW_OFF_PER0 + 12'h008, 32'h4);
    xfer(1'h1, `EPW_OFF_DTY0 + 12'h008, 32'h2);
    xfer(1'h1, `EPW_OFF_CENTER, 32'h4);
    xfer(1'h1, `EPW_OFF_POL, 32'h4);
    xfer(1'h1, `EPW_OFF_ENABLE, 32'h5);
    cnt(2, 16, 6);
    cnt(0, 16, 12);
  endtask
  task automatic t_join;
    xfer(1'h1, `EPW_OFF_ENABLE, 32'h0);
    xfer(1'h1, `EPW_OFF_CONCAT, 32'h9);
    xfer(1'h1, `EPW_OFF_PER0, 32'h0);
    xfer(1'h1, `EPW_OFF_PER0 + 12'h004, 32'h1);
    xfer(1'h1, `EPW_OFF_DTY0, 32'h80);
    xfer(1'h1, `EPW_OFF_DTY0 + 12'h004, 32'h0);
    xfer(1'h1, `EPW_OFF_POL, 32'h82);
    xfer(1'h1, `EPW_OFF_ENABLE, 32'h2);
    cnt(1, 256, 128);
    cnt(0, 16, 0);
    chk("idle_pol", 32'h1, {31'h0, pwm_out[7]});
  endtask
  task automatic t_refuse;
    @(posedge hclk);
    hsize <= 3'h0;
    xfer(1'h0, `EPW_OFF_PER0, 32'h0);
    chk("size_rd", 32'h0, rdat);
    hsize <= 3'h2;
    xfer(1'h0, 12'h0FC, 32'h0);
    chk("unmap_rd", 32'h0, rdat);
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_left();
    t_centre();
    t_join();
    t_refuse();
    stop_test();
  end
endmodule
`default_nettype wire
